//--- common/tmpal_pkg.sv
// constants, register map and types of the temperature alarm and alert logic
package tmpal_pkg;
	// read addresses
	localparam logic [7:0] RD_LOCAL_TEMP        = 8'h00;
	localparam logic [7:0] RD_REMOTE_TEMP       = 8'h01;
	localparam logic [7:0] RD_STATUS            = 8'h02;
	localparam logic [7:0] RD_CONFIG            = 8'h03;
	localparam logic [7:0] RD_LOCAL_HIGH        = 8'h05;
	localparam logic [7:0] RD_LOCAL_LOW         = 8'h06;
	localparam logic [7:0] RD_REMOTE_HIGH       = 8'h07;
	localparam logic [7:0] RD_REMOTE_LOW        = 8'h08;
	localparam logic [7:0] RD_IDENT             = 8'hfe;
	// write addresses
	localparam logic [7:0] WR_CONFIG            = 8'h09;
	localparam logic [7:0] WR_LOCAL_HIGH        = 8'h0b;
	localparam logic [7:0] WR_LOCAL_LOW         = 8'h0c;
	localparam logic [7:0] WR_REMOTE_HIGH       = 8'h0d;
	localparam logic [7:0] WR_REMOTE_LOW        = 8'h0e;
	localparam logic [7:0] WR_SINGLE_CONV       = 8'h0f;
	// shared read and write addresses
	localparam logic [7:0] RW_REMOTE_FAILSAFE   = 8'h19;
	localparam logic [7:0] RW_LOCAL_FAILSAFE    = 8'h20;
	localparam logic [7:0] RW_HYSTERESIS        = 8'h21;
	// reset values
	localparam logic [7:0] RST_CONFIG           = 8'h00;
	localparam logic [7:0] RST_TEMP             = 8'h00;
	localparam logic [7:0] RST_HIGH_LIMIT       = 8'h55;
	localparam logic [7:0] RST_LOW_LIMIT        = 8'h00;
	localparam logic [7:0] RST_FAILSAFE_LIMIT   = 8'h55;
	localparam logic [7:0] RST_HYSTERESIS       = 8'h0a;
	// value of the identification register, arbitrary
	localparam logic [7:0] IDENT_CODE           = 8'h5a;
	// field positions
	localparam int         CFG_STANDBY_BIT      = 6;
	localparam int         CFG_ALERT_MASK_BIT   = 7;
	localparam int         STS_BUSY_BIT         = 7;
	localparam int         STS_LOCAL_HIGH_BIT   = 6;
	localparam int         STS_LOCAL_LOW_BIT    = 5;
	localparam int         STS_REMOTE_HIGH_BIT  = 4;
	localparam int         STS_REMOTE_LOW_BIT   = 3;
	localparam int         STS_OPEN_BIT         = 2;
	localparam int         STS_REMOTE_FS_BIT    = 1;
	localparam int         STS_LOCAL_FS_BIT     = 0;
	// alert response
	localparam logic [6:0] ALERT_RESP_ADDR      = 7'h0c;
	localparam logic [3:0] ADDR_BITS            = 4'h8;
	localparam logic [7:0] UNDER_RANGE_CODE     = 8'h80;
	// channels and timing
	localparam int         CH_LOCAL             = 0;
	localparam int         CH_REMOTE            = 1;
	localparam int         NUM_CH               = 2;
	localparam int         CLK_MHZ              = 100;
	localparam int         CONV_PERIOD_US       = 125000;
	localparam int         CONV_PERIOD_CYC      = CONV_PERIOD_US * CLK_MHZ;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_BUSY = 2'b10
	} tmpal_conv_t;
endpackage

//--- common/tmpal_cmp_if.sv
// limit comparison signals of one temperature channel
`timescale 1ns/1ps
`default_nettype none
interface tmpal_cmp_if;
	logic signed [7:0] temp;
	logic signed [7:0] high_lim;
	logic signed [7:0] low_lim;
	logic signed [7:0] fs_lim;
	logic        [7:0] hyst;
	logic              high_viol;
	logic              low_viol;
	logic              fs_over;
	logic              fs_clear;
	modport ctrl (output temp, high_lim, low_lim, fs_lim, hyst,
		input high_viol, low_viol, fs_over, fs_clear);
	modport cmp (input temp, high_lim, low_lim, fs_lim, hyst,
		output high_viol, low_viol, fs_over, fs_clear);
endinterface
`default_nettype wire

//--- src/tmpal_limit_cmp.sv
// limit comparators of one temperature channel
`timescale 1ns/1ps
`default_nettype none
module tmpal_limit_cmp (
	// channel values and results
	tmpal_cmp_if.cmp c
);
	logic signed [9:0] release_pt;
	logic signed [9:0] temp_wide;

	// ten bits so that a large hysteresis below -128 cannot wrap round
	always_comb begin
		release_pt = $signed({{2{c.fs_lim[7]}}, c.fs_lim}) - $signed({2'b00, c.hyst});
		temp_wide  = $signed({{2{c.temp[7]}}, c.temp});
		c.high_viol = c.temp > c.high_lim;
		c.low_viol  = c.temp <= c.low_lim;
		c.fs_over   = c.temp > c.fs_lim;
		c.fs_clear  = temp_wide <= release_pt;
	end
endmodule
`default_nettype wire

//--- src/tmpal_ara_resp.sv
// alert response: shifts the own address out on the data line with arbitration
`timescale 1ns/1ps
`default_nettype none
module tmpal_ara_resp (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// bit timing from the bus front end
	input  wire logic       start_i,
	input  wire logic       drive_i,
	input  wire logic       sample_i,
	input  wire logic       sda_in_i,
	input  wire logic [6:0] dev_addr_i,
	// results
	output logic            sda_oe_o,
	output logic            answered_o,
	output logic            busy_o
);
	logic [7:0] shift;
	logic [3:0] left;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			busy_o     <= 1'b0;
			sda_oe_o   <= 1'b0;
			answered_o <= 1'b0;
			shift      <= 8'h00;
			left       <= 4'h0;
		end else begin
			answered_o <= 1'b0;
			if (start_i) begin
				busy_o   <= 1'b1;
				shift    <= {dev_addr_i, 1'b1};
				left     <= tmpal_pkg::ADDR_BITS;
				sda_oe_o <= 1'b0;
			end else if (busy_o && drive_i) begin
				sda_oe_o <= ~shift[7];
			end else if (busy_o && sample_i) begin
				// a released one read back as zero: a lower address won
				if (!sda_oe_o && !sda_in_i) begin
					busy_o   <= 1'b0;
					sda_oe_o <= 1'b0;
				end else begin
					shift <= {shift[6:0], 1'b0};
					left  <= left - 4'h1;
					if (left == 4'h1) begin
						busy_o     <= 1'b0;
						sda_oe_o   <= 1'b0;
						answered_o <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- src/tmpal_top.sv
// alarm, alert and fail-safe logic of a two-channel temperature monitor
//
// Function
// - alert pin goes low on any out-of-limit value or open remote diode.
// - an alerting device answers with its seven-bit address plus a one.
// - simultaneous answers arbitrate; lowest address wins, losers withdraw.
// - after answering, alert releases only if its cause has gone.
// - configuration bit 6 clear runs normally, set enters standby.
// - entering standby aborts a periodic conversion and discards its partial result.
// - register reads and writes keep working in standby.
// - a write to 0Fh in standby converts both channels once.
// - limits rewritten in standby still raise alert against stored values.
// - alert when a temperature is at or below its low limit.
// - alert when a temperature is above its high limit.
// - no alert for a temperature strictly between its limits.
// - fail-safe pin goes low when a temperature exceeds its fail-safe limit.
// - alert is maskable; fail-safe output has no mask.
// - one shared hysteresis value, resets to ten degrees, always writable.
// - hysteresis is unsigned, one degree per step.
// - open-diode detector is sampled at conversion start into status bit 2.
// - remote value below range reads as code 80h, minus 128.
// - minus 128 always alerts because the low check includes equality.
// - any write to the single-conversion address triggers; data is ignored.
// - registers decode distinct read and write addresses, except the fail-safe limits and hysteresis, which share one.
`timescale 1ns/1ps
`default_nettype none
module tmpal_top #(
	parameter int       CONV_CYC = tmpal_pkg::CONV_PERIOD_CYC,
	parameter bit [6:0] DEV_ADDR = 7'h2a
) (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// register access from the serial bus front end
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// alert response on the serial data line
	input  wire logic [6:0] bus_addr_i,
	input  wire logic       bus_addr_rd_i,
	input  wire logic       bit_drive_i,
	input  wire logic       bit_sample_i,
	input  wire logic       serial_data_line_i,
	output logic            serial_data_line_o,
	output logic            serial_data_line_oe_o,
	// converter
	input  wire logic       conv_done_i,
	input  wire logic [7:0] local_meas_i,
	input  wire logic [7:0] remote_meas_i,
	input  wire logic       remote_under_range_i,
	input  wire logic       open_fault_i,
	output logic            conv_start_o,
	output logic            conv_abort_o,
	// alarm pins and mode
	output logic            alert_n_o,
	output logic            alert_oe_o,
	output logic            failsafe_overtemp_n_o,
	output logic            failsafe_overtemp_oe_o,
	output logic            standby_o
);
	localparam int CH_L = tmpal_pkg::CH_LOCAL;
	localparam int CH_R = tmpal_pkg::CH_REMOTE;
	localparam logic [23:0] PERIOD_LAST = 24'(CONV_CYC - 1);

	logic [7:0]  cfg;
	logic [7:0]  high_lim [tmpal_pkg::NUM_CH];
	logic [7:0]  low_lim  [tmpal_pkg::NUM_CH];
	logic [7:0]  fs_lim   [tmpal_pkg::NUM_CH];
	logic [7:0]  temp     [tmpal_pkg::NUM_CH];
	logic [7:0]  hyst;
	logic        open_flag;
	logic        single_pend;
	logic        single_run;
	logic [23:0] period_cnt;
	tmpal_pkg::tmpal_conv_t state;
	logic        alert_act;
	logic        next_alert;
	logic [1:0]  fs_act;
	logic [1:0]  next_fs_act;
	logic [1:0]  high_v;
	logic [1:0]  low_v;
	logic [1:0]  fs_over;
	logic [1:0]  fs_clear;
	logic        cond;
	logic        mask;
	logic        standby;
	logic        wr_single;
	logic        start_req;
	logic        ara_start;
	logic        answered;
	logic        ara_oe;
	logic        ara_busy;

	assign mask      = cfg[tmpal_pkg::CFG_ALERT_MASK_BIT];
	assign standby   = cfg[tmpal_pkg::CFG_STANDBY_BIT];
	assign wr_single = reg_wr_i && reg_addr_i == tmpal_pkg::WR_SINGLE_CONV;
	assign start_req = (!standby && period_cnt == PERIOD_LAST) || single_pend;

	// one comparator per channel, evaluated on stored values all the time
	tmpal_cmp_if cmp_bus [tmpal_pkg::NUM_CH] ();
	for (genvar i = 0; i < tmpal_pkg::NUM_CH; i++) begin : g_ch
		assign cmp_bus[i].temp     = temp[i];
		assign cmp_bus[i].high_lim = high_lim[i];
		assign cmp_bus[i].low_lim  = low_lim[i];
		assign cmp_bus[i].fs_lim   = fs_lim[i];
		assign cmp_bus[i].hyst     = hyst;
		assign high_v[i]   = cmp_bus[i].high_viol;
		assign low_v[i]    = cmp_bus[i].low_viol;
		assign fs_over[i]  = cmp_bus[i].fs_over;
		assign fs_clear[i] = cmp_bus[i].fs_clear;
		tmpal_limit_cmp u_cmp (
			.c (cmp_bus[i])
		);
	end

	// register writes; the bus keeps working in standby
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cfg            <= tmpal_pkg::RST_CONFIG;
			high_lim[CH_L] <= tmpal_pkg::RST_HIGH_LIMIT;
			high_lim[CH_R] <= tmpal_pkg::RST_HIGH_LIMIT;
			low_lim[CH_L]  <= tmpal_pkg::RST_LOW_LIMIT;
			low_lim[CH_R]  <= tmpal_pkg::RST_LOW_LIMIT;
			fs_lim[CH_L]   <= tmpal_pkg::RST_FAILSAFE_LIMIT;
			fs_lim[CH_R]   <= tmpal_pkg::RST_FAILSAFE_LIMIT;
			hyst           <= tmpal_pkg::RST_HYSTERESIS;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				tmpal_pkg::WR_CONFIG:          cfg            <= reg_wdata_i;
				tmpal_pkg::WR_LOCAL_HIGH:      high_lim[CH_L] <= reg_wdata_i;
				tmpal_pkg::WR_LOCAL_LOW:       low_lim[CH_L]  <= reg_wdata_i;
				tmpal_pkg::WR_REMOTE_HIGH:     high_lim[CH_R] <= reg_wdata_i;
				tmpal_pkg::WR_REMOTE_LOW:      low_lim[CH_R]  <= reg_wdata_i;
				tmpal_pkg::RW_LOCAL_FAILSAFE:  fs_lim[CH_L]   <= reg_wdata_i;
				tmpal_pkg::RW_REMOTE_FAILSAFE: fs_lim[CH_R]   <= reg_wdata_i;
				tmpal_pkg::RW_HYSTERESIS:      hyst           <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// register reads; unmapped and write-only addresses read as zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				tmpal_pkg::RD_LOCAL_TEMP:      reg_rdata_o <= temp[CH_L];
				tmpal_pkg::RD_REMOTE_TEMP:     reg_rdata_o <= temp[CH_R];
				tmpal_pkg::RD_STATUS:          reg_rdata_o <= {state == tmpal_pkg::CONV_BUSY,
					high_v[CH_L], low_v[CH_L], high_v[CH_R], low_v[CH_R], open_flag,
					fs_act[CH_R], fs_act[CH_L]};
				tmpal_pkg::RD_CONFIG:          reg_rdata_o <= cfg;
				tmpal_pkg::RD_LOCAL_HIGH:      reg_rdata_o <= high_lim[CH_L];
				tmpal_pkg::RD_LOCAL_LOW:       reg_rdata_o <= low_lim[CH_L];
				tmpal_pkg::RD_REMOTE_HIGH:     reg_rdata_o <= high_lim[CH_R];
				tmpal_pkg::RD_REMOTE_LOW:      reg_rdata_o <= low_lim[CH_R];
				tmpal_pkg::RW_LOCAL_FAILSAFE:  reg_rdata_o <= fs_lim[CH_L];
				tmpal_pkg::RW_REMOTE_FAILSAFE: reg_rdata_o <= fs_lim[CH_R];
				tmpal_pkg::RW_HYSTERESIS:      reg_rdata_o <= hyst;
				tmpal_pkg::RD_IDENT:           reg_rdata_o <= tmpal_pkg::IDENT_CODE;
				default:                       reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// conversion rate divider, cleared while in standby
	always_ff @(posedge core_clk_i) begin
		if (rst_i || standby || period_cnt == PERIOD_LAST) begin
			period_cnt <= 24'h000000;
		end else begin
			period_cnt <= period_cnt + 24'h000001;
		end
	end

	// a single-conversion request waits until the converter is idle
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			single_pend <= 1'b0;
		end else if (wr_single) begin
			single_pend <= 1'b1;
		end else if (state == tmpal_pkg::CONV_IDLE) begin
			single_pend <= 1'b0;
		end
	end

	// conversion sequencer
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state        <= tmpal_pkg::CONV_IDLE;
			single_run   <= 1'b0;
			conv_start_o <= 1'b0;
			conv_abort_o <= 1'b0;
			open_flag    <= 1'b0;
			temp[CH_L]   <= tmpal_pkg::RST_TEMP;
			temp[CH_R]   <= tmpal_pkg::RST_TEMP;
		end else begin
			conv_start_o <= 1'b0;
			conv_abort_o <= 1'b0;
			unique case (state)
				tmpal_pkg::CONV_IDLE: begin
					if (start_req) begin
						state        <= tmpal_pkg::CONV_BUSY;
						single_run   <= single_pend;
						conv_start_o <= 1'b1;
						open_flag    <= open_fault_i;
					end
				end
				tmpal_pkg::CONV_BUSY: begin
					if (standby && !single_run) begin
						// partial result is dropped, stored values stay
						state        <= tmpal_pkg::CONV_IDLE;
						conv_abort_o <= 1'b1;
					end else if (conv_done_i) begin
						state      <= tmpal_pkg::CONV_IDLE;
						single_run <= 1'b0;
						temp[CH_L] <= local_meas_i;
						temp[CH_R] <= remote_under_range_i ?
							tmpal_pkg::UNDER_RANGE_CODE : remote_meas_i;
					end
				end
			endcase
		end
	end

	// alert latch: set beats the release after an alert response
	assign cond = |(high_v | low_v) || open_flag;
	always_comb begin
		next_alert = alert_act;
		if (cond && !mask) begin
			next_alert = 1'b1;
		end else if (mask || (answered && !cond)) begin
			next_alert = 1'b0;
		end
	end

	// fail-safe per channel with shared hysteresis, never masked
	always_comb begin
		for (int i = 0; i < tmpal_pkg::NUM_CH; i++) begin
			next_fs_act[i] = fs_act[i];
			if (fs_over[i]) begin
				next_fs_act[i] = 1'b1;
			end else if (fs_clear[i]) begin
				next_fs_act[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			alert_act              <= 1'b0;
			alert_n_o              <= 1'b1;
			alert_oe_o             <= 1'b0;
			fs_act                 <= 2'b00;
			failsafe_overtemp_n_o  <= 1'b1;
			failsafe_overtemp_oe_o <= 1'b0;
			standby_o              <= 1'b0;
			serial_data_line_o     <= 1'b0;
		end else begin
			alert_act              <= next_alert;
			alert_n_o              <= ~next_alert;
			alert_oe_o             <= next_alert;
			fs_act                 <= next_fs_act;
			failsafe_overtemp_n_o  <= ~|next_fs_act;
			failsafe_overtemp_oe_o <= |next_fs_act;
			standby_o              <= standby;
			serial_data_line_o     <= 1'b0;
		end
	end

	// answer the alert response address only while alerting
	assign ara_start = bus_addr_rd_i && bus_addr_i == tmpal_pkg::ALERT_RESP_ADDR
		&& alert_act;

	tmpal_ara_resp u_ara (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.start_i    (ara_start),
		.drive_i    (bit_drive_i),
		.sample_i   (bit_sample_i),
		.sda_in_i   (serial_data_line_i),
		.dev_addr_i (DEV_ADDR),
		.sda_oe_o   (ara_oe),
		.answered_o (answered),
		.busy_o     (ara_busy)
	);
	assign serial_data_line_oe_o = ara_oe;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	logic fs_release_ok;
	assign fs_release_ok = (!fs_act[0] || fs_clear[0]) && (!fs_act[1] || fs_clear[1]);

	sequence s_single_wr;
		wr_single && standby && state == tmpal_pkg::CONV_IDLE && !single_pend;
	endsequence
	sequence s_standby_busy;
		state == tmpal_pkg::CONV_BUSY && standby && !single_run && !conv_done_i;
	endsequence

	a_alert_limit: assert property ((|(high_v | low_v)) && !mask |=> alert_oe_o && !alert_n_o)
		else $error("alert not driven on limit violation");
	a_alert_open: assert property (open_flag && !mask |=> alert_oe_o)
		else $error("alert not driven for open diode");
	a_alert_release: assert property (alert_oe_o && !answered && !mask |=> alert_oe_o)
		else $error("alert released without a response");
	a_alert_masked: assert property (mask |=> !alert_oe_o)
		else $error("masked alert still driven");
	a_single_start: assert property (s_single_wr |=> ##1 conv_start_o ##1 !conv_start_o)
		else $error("single conversion did not start");
	a_standby_abort: assert property (s_standby_busy |=> conv_abort_o
		&& $stable(temp[CH_R]) && state == tmpal_pkg::CONV_IDLE)
		else $error("conversion not aborted on standby");
	a_open_sample: assert property (conv_start_o |-> open_flag == $past(open_fault_i))
		else $error("open detector not sampled at start");
	a_fs_assert: assert property (|fs_over |=> failsafe_overtemp_oe_o
		&& !failsafe_overtemp_n_o)
		else $error("fail-safe not driven above its limit");
	a_fs_hyst: assert property ($fell(failsafe_overtemp_oe_o) |-> $past(fs_release_ok))
		else $error("fail-safe released inside hysteresis band");
	a_short_alert: assert property (conv_done_i && remote_under_range_i && !mask
		&& state == tmpal_pkg::CONV_BUSY && !(standby && !single_run) |=> ##1 alert_oe_o)
		else $error("under-range remote value did not alert");
	a_ara_gate: assert property (ara_start |-> alert_oe_o ##1 ara_busy)
		else $error("alert response started while not alerting");
	a_standby_idle: assert property (standby && !single_pend |=> !conv_start_o)
		else $error("conversion started in standby without a request");
	a_alert_clear: assert property (answered && !cond && !mask |=> !alert_oe_o)
		else $error("alert kept after response with cause gone");
	a_quiet_window: assert property (!cond && !alert_oe_o |=> !alert_oe_o)
		else $error("alert raised with values inside limits");
	a_ara_withdraw: assert property (!ara_busy |-> !serial_data_line_oe_o)
		else $error("data line driven outside a response");
endmodule
`default_nettype wire

//--- verif/tmpal_host_model.sv
// bus host model: alert response read, optionally against a competing responder
`timescale 1ns/1ps
`default_nettype none
module tmpal_host_model (
	// clock
	input  wire logic       clk_i,
	// device responder enable
	input  wire logic       dev_oe_i,
	// front end strobes and wired line
	output logic      [6:0] addr_o,
	output logic            addr_rd_o,
	output logic            drive_o,
	output logic            sample_o,
	output logic            line_o
);
	logic [7:0] rival;
	logic       rival_on;
	logic       rival_oe;
	initial begin
		{addr_o, addr_rd_o, drive_o, sample_o} = 10'h000;
		{rival, rival_on, rival_oe} = 10'h000;
	end
	// pulled-up wire, low while any responder pulls it
	assign line_o = ~(dev_oe_i | rival_oe);
	task automatic ara(input logic [6:0] other, input logic use_other, output logic [7:0] got);
		rival = {other, 1'b1};
		rival_on = use_other;
		addr_o = tmpal_pkg::ALERT_RESP_ADDR;
		addr_rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		addr_rd_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			drive_o = 1'b1;
			rival_oe = rival_on & ~rival[i];
			@(posedge clk_i);
			#1;
			drive_o = 1'b0;
			@(posedge clk_i);
			#1;
			sample_o = 1'b1;
			got[i] = line_o;
			// a losing rival withdraws like a real responder
			if (rival_on && !rival_oe && !line_o) rival_on = 1'b0;
			@(posedge clk_i);
			#1;
			sample_o = 1'b0;
		end
		rival_oe = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- verif/test_tmpal_top.sv
// self-checking bench of the alarm and alert logic
`timescale 1ns/1ps
`default_nettype none
module test_tmpal_top;
	localparam logic [6:0] DEV = 7'h2a;
	localparam logic [7:0] ME  = {DEV, 1'b1};
	logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done = 1'b0, ur = 1'b0, openf = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, lmeas = 8'h00, rmeas = 8'h00, rdata, got, seen;
	logic [6:0] baddr;
	logic       brd, bdrv, bsmp, line, sda, sda_oe, cstart, cabort;
	logic       alert_n, alert_oe, fs_n, fs_oe, stby;
	int         fail_count = 0, num_checks = 0, cyc = 0;
	tmpal_top #(.CONV_CYC(200), .DEV_ADDR(DEV)) uut (.core_clk_i(clk), .rst_i(rst),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .bus_addr_i(baddr), .bus_addr_rd_i(brd), .bit_drive_i(bdrv),
		.bit_sample_i(bsmp), .serial_data_line_i(line), .serial_data_line_o(sda),
		.serial_data_line_oe_o(sda_oe), .conv_done_i(done), .local_meas_i(lmeas),
		.remote_meas_i(rmeas), .remote_under_range_i(ur), .open_fault_i(openf),
		.conv_start_o(cstart), .conv_abort_o(cabort), .alert_n_o(alert_n),
		.alert_oe_o(alert_oe), .failsafe_overtemp_n_o(fs_n),
		.failsafe_overtemp_oe_o(fs_oe), .standby_o(stby));
	tmpal_host_model host (.clk_i(clk), .dev_oe_i(sda_oe), .addr_o(baddr), .addr_rd_o(brd),
		.drive_o(bdrv), .sample_o(bsmp), .line_o(line));
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] val);
		num_checks++;
		if (val !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, val);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic al(input logic e);
		chk("alert_n_o", {7'h00, e}, {7'h00, alert_n});
		chk("alert_oe_o", {7'h00, ~e}, {7'h00, alert_oe});
	endtask
	task automatic fs(input logic e);
		chk("failsafe_overtemp_n_o", {7'h00, e}, {7'h00, fs_n});
		chk("failsafe_overtemp_oe_o", {7'h00, ~e}, {7'h00, fs_oe});
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		tick(1);
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		chk(name, exp, rdata);
		tick(1);
	endtask
	task automatic wait_start(input int lim);
		for (int i = 0; i < lim && cstart !== 1'b1; i++) tick(1);
		chk("conv_start_o", 8'h01, {7'h00, cstart});
	endtask
	task automatic conv(input logic [7:0] l, input logic [7:0] r, input logic u, input logic o);
		openf = o;
		wr_reg(tmpal_pkg::WR_SINGLE_CONV, 8'ha5);
		wait_start(8);
		{lmeas, rmeas, ur, done} = {l, r, u, 1'b1};
		tick(1);
		done = 1'b0;
		tick(3);
	endtask
	task automatic ara(input logic [6:0] other, input logic use_other, input logic [7:0] exp,
		input logic alert_exp);
		host.ara(other, use_other, got);
		chk("alert response byte", exp, got);
		chk("serial_data_line_oe_o", 8'h00, {7'h00, sda_oe});
		chk("serial_data_line_o", 8'h00, {7'h00, sda});
		tick(3);
		al(alert_exp);
	endtask
	task automatic t_abort;
		al(1'b0);
		wait_start(260);
		{addr, wdata, wr} = {tmpal_pkg::WR_CONFIG, 8'h40, 1'b1};
		tick(1);
		wr = 1'b0;
		seen = {7'h00, cabort};
		tick(1);
		seen[0] |= cabort;
		chk("conv_abort_o", 8'h01, seen);
		chk("standby_o", 8'h01, {7'h00, stby});
		{lmeas, done} = {8'h33, 1'b1};
		tick(1);
		done = 1'b0;
		tick(2);
		rd_chk("local temp", tmpal_pkg::RD_LOCAL_TEMP, 8'h00);
	endtask
	task automatic t_regs;
		logic [7:0] ra[4] = '{tmpal_pkg::RD_LOCAL_HIGH, tmpal_pkg::RD_REMOTE_HIGH,
			tmpal_pkg::RW_LOCAL_FAILSAFE, tmpal_pkg::RW_HYSTERESIS};
		logic [7:0] rv[4] = '{8'h55, 8'h55, 8'h55, 8'h0a};
		for (int i = 0; i < 4; i++) rd_chk("reset value", ra[i], rv[i]);
		wr_reg(tmpal_pkg::RW_HYSTERESIS, 8'h05);
		rd_chk("hysteresis", tmpal_pkg::RW_HYSTERESIS, 8'h05);
		wr_reg(tmpal_pkg::RW_HYSTERESIS, 8'h0a);
		rd_chk("write address read", tmpal_pkg::WR_LOCAL_HIGH, 8'h00);
		rd_chk("config", tmpal_pkg::RD_CONFIG, 8'h40);
		rd_chk("ident", tmpal_pkg::RD_IDENT, tmpal_pkg::IDENT_CODE);
	endtask
	task automatic t_window;
		// high limits stay below the fail-safe limits
		wr_reg(tmpal_pkg::WR_LOCAL_HIGH, 8'h32);
		wr_reg(tmpal_pkg::WR_REMOTE_HIGH, 8'h32);
		wr_reg(tmpal_pkg::WR_LOCAL_LOW, 8'hec);
		wr_reg(tmpal_pkg::WR_REMOTE_LOW, 8'hec);
		conv(8'h32, 8'h14, 1'b0, 1'b0);
		ara(7'h00, 1'b0, ME, 1'b1);
		conv(8'h33, 8'h14, 1'b0, 1'b0);
		al(1'b0);
		ara(7'h00, 1'b0, ME, 1'b0);
		conv(8'h10, 8'hec, 1'b0, 1'b0);
		ara(7'h00, 1'b0, ME, 1'b0);
		conv(8'h10, 8'hed, 1'b0, 1'b0);
		ara(7'h00, 1'b0, ME, 1'b1);
	endtask
	task automatic t_limit_arb;
		wr_reg(tmpal_pkg::WR_LOCAL_LOW, 8'h10);
		tick(2);
		al(1'b0);
		ara(7'h10, 1'b1, {7'h10, 1'b1}, 1'b0);
		wr_reg(tmpal_pkg::WR_LOCAL_LOW, 8'hec);
		ara(7'h00, 1'b0, ME, 1'b1);
	endtask
	task automatic t_faults;
		conv(8'h10, 8'h00, 1'b1, 1'b0);
		rd_chk("remote temp", tmpal_pkg::RD_REMOTE_TEMP, 8'h80);
		wr_reg(tmpal_pkg::WR_REMOTE_LOW, 8'h80);
		ara(7'h00, 1'b0, ME, 1'b0);
		conv(8'h10, 8'hed, 1'b0, 1'b1);
		rd_chk("status", tmpal_pkg::RD_STATUS, 8'h04);
		ara(7'h00, 1'b0, ME, 1'b0);
		conv(8'h10, 8'hed, 1'b0, 1'b0);
		rd_chk("status", tmpal_pkg::RD_STATUS, 8'h00);
		ara(7'h00, 1'b0, ME, 1'b1);
	endtask
	task automatic t_failsafe;
		wr_reg(tmpal_pkg::WR_CONFIG, 8'hc0);
		conv(8'h56, 8'hed, 1'b0, 1'b0);
		fs(1'b0);
		al(1'b1);
		rd_chk("status", tmpal_pkg::RD_STATUS, 8'h41);
		conv(8'h4c, 8'hed, 1'b0, 1'b0);
		fs(1'b0);
		conv(8'h4b, 8'hed, 1'b0, 1'b0);
		fs(1'b1);
		wr_reg(tmpal_pkg::WR_CONFIG, 8'h40);
		tick(2);
		al(1'b0);
	endtask
	initial begin
		forever #5 clk = ~clk;
	end
	// hang guard, far beyond the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		tick(3);
		t_abort;
		t_regs;
		t_window;
		t_limit_arb;
		t_faults;
		t_failsafe;
		stop_test;
	end
endmodule
`default_nettype wire
